// file: shared/dli_pkg.sv
// Purpose: constants, register map and types of the die link initiator control block
// Assumes: 8-bit register bus with 16-bit addresses, one bus clock
// Notes: window pages and link command codes are local choices
// Notes on behaviour
// RULE1: eight control registers plus blocking and non-blocking 256-byte windows
// RULE2: link enable takes only the first write unless in special mode
// RULE3: link disabled means no link line is used, pins released
// RULE4: enabled link drives active data lines low as idle command
// RULE5: enabled link drives a continuous clock, bus clock divided by ratio
// RULE6: width bit 0 uses lanes 3:0 only, width bit 1 uses all eight
// RULE7: stop-in-wait always writable; set stops link clock in wait mode
// RULE8: divider codes 00,01,10,11 give divide by 1,2,3,4
// RULE9: divider field write-once in normal mode, free in special mode
// RULE10: link clock high phase never longer than half the period; at divide by 1 the code holds o_link_clk high for as long as the link runs
// RULE11: after enable written to 1 in normal mode, write-once bits ignore writes
// RULE12: target interrupt enable gates the interrupt input from the target
// RULE13: timeout field counts link clocks for acknowledge; expiry sets timeout flag
// RULE14: timeout field write-once in normal mode, free in special mode
// RULE15: setting zero requires acknowledge right after the last transfer cycle
// RULE16: nonzero setting allows that many wait states, later acknowledge times out
// RULE17: window write sends write command, 8-bit address, then data
// RULE18: window read sends read command and 8-bit address, target returns data
// RULE19: stop or stopping wait drives clock and data low after high phase
// RULE20: any transaction error sets an error summary flag that cannot be masked
// RULE21: ratios above one hold clock high one bus cycle per period
// RULE22: reserved bits read zero; status and capture registers ignore writes; the code clears the error flags when status 0 bit 7 is written with 1
package dli_pkg;
    localparam int ADDR_W = 16;
    // control register byte addresses
    localparam logic [15:0] CTL0_ADDR = 16'h00D8;
    localparam logic [15:0] CTL1_ADDR = 16'h00D9;
    localparam logic [15:0] STAT0_ADDR = 16'h00DA;
    localparam logic [15:0] STAT1_ADDR = 16'h00DB;
    localparam logic [15:0] ATTR_ADDR = 16'h00DC;
    localparam logic [15:0] CADR_ADDR = 16'h00DD;
    localparam logic [15:0] DHI_ADDR = 16'h00DE;
    localparam logic [15:0] DLO_ADDR = 16'h00DF;
    // window pages: upper address byte selects a 256-byte window
    localparam logic [7:0] BLK_PAGE = 8'h02;
    localparam logic [7:0] NBLK_PAGE = 8'h03;
    // link command codes sent in the command cycle
    localparam logic [7:0] CMD_WRITE = 8'hA5;
    localparam logic [7:0] CMD_READ = 8'h5A;
    // field positions
    localparam int CTL0_EN_BIT = 7;
    localparam int CTL0_CW_BIT = 6;
    localparam int CTL0_SWAI_BIT = 5;
    localparam int CTL1_IE_BIT = 7;
    localparam logic [7:0] CTL0_RESET = 8'h00;
    localparam logic [7:0] CTL1_RESET = 8'h00;
    localparam logic [7:0] ERROR_SUMMARY_FLAG_MASK = 8'h80;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [7:0] LANES_ALL = 8'hFF;
    localparam logic [7:0] LANES_LOW = 8'h0F;

    typedef enum logic [2:0] {
        DLI_IDLE = 3'b000,
        DLI_CMD = 3'b001,
        DLI_ADDR = 3'b010,
        DLI_DATA = 3'b011,
        DLI_ACK = 3'b100,
        DLI_RDAT = 3'b101
    } dli_state_t;

    // configuration held in the control registers
    typedef struct packed {
        logic link_enable;
        logic link_width_select;
        logic stop_in_wait;
        logic [1:0] link_clock_divider;
        logic target_interrupt_enable;
        logic [3:0] wait_state_limit;
    } dli_cfg_t;

    // capture of the transaction in flight
    typedef struct packed {
        logic rwb;
        logic nblk;
        logic [7:0] addr;
        logic [7:0] data;
    } dli_txn_t;
endpackage : dli_pkg

// file: hdl/dli_initiator.sv
// Purpose: control, configuration and link sequencing of the die link initiator
// Assumes: pins and mode inputs synchronous to i_mclk; byte-wide register bus
// Notes: o_link_clk is a cycle-level clock; at divide by 1 it stays high and the pad
//        gate forms the clock from the bus clock
`timescale 1ns/1ps
module dli_initiator
    import dli_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_special_mode,
    input wire logic i_stop_mode,
    input wire logic i_wait_mode,
    output logic o_link_active,
    output logic o_link_clk,
    output logic [7:0] o_dat_out,
    output logic [7:0] o_dat_oe_n,
    input wire logic [7:0] i_dat_in,
    input wire logic i_target_int,
    output logic o_target_irq,
    output logic o_error_irq
);
    dli_cfg_t cfg_reg;
    dli_txn_t txn_reg;
    dli_state_t state_reg;
    logic [1:0] div_cnt_reg;
    logic [1:0] div_cnt_next;
    logic [2:0] ratio;
    logic run;
    logic tick;
    logic stop_req;
    logic locked;
    logic nib_reg;
    logic [3:0] wait_cnt_reg;
    logic busy_reg;
    logic err_reg;
    logic timeout_error_flag_reg;
    logic cnclf_reg;
    logic in_window;
    logic launch;
    logic cancel;
    logic ack_seen;
    logic timeout_hit;
    logic last_part;
    logic [7:0] cur_byte;
    logic [7:0] part;
    logic [7:0] lanes;
    logic wr_ctl0;
    logic wr_ctl1;
    logic err_clear;

    // write-once fields freeze once enabled outside special mode
    // RULE11 lock after enable
    assign locked = cfg_reg.link_enable & ~i_special_mode;
    assign wr_ctl0 = i_wr & (i_addr == CTL0_ADDR);
    assign wr_ctl1 = i_wr & (i_addr == CTL1_ADDR);
    assign err_clear = i_wr & (i_addr == STAT0_ADDR) & (|(i_wdata & ERROR_SUMMARY_FLAG_MASK));
    assign stop_req = i_stop_mode | (i_wait_mode & cfg_reg.stop_in_wait);
    assign lanes = cfg_reg.link_width_select ? LANES_ALL : LANES_LOW;

    // control registers; reserved bits are never stored
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg_reg <= '0;
        end else begin
            if (wr_ctl0) begin
                // RULE7 always writable
                cfg_reg.stop_in_wait <= i_wdata[CTL0_SWAI_BIT];
                // RULE2 RULE9 write-once fields
                if (!locked) begin
                    cfg_reg.link_enable <= i_wdata[CTL0_EN_BIT];
                    cfg_reg.link_width_select <= i_wdata[CTL0_CW_BIT];
                    cfg_reg.link_clock_divider <= i_wdata[1:0];
                end
            end
            if (wr_ctl1) begin
                cfg_reg.target_interrupt_enable <= i_wdata[CTL1_IE_BIT];
                // RULE14 timeout write-once
                if (!locked) begin
                    cfg_reg.wait_state_limit <= i_wdata[3:0];
                end
            end
        end
    end

    // divider: ratio is code plus one, high phase one bus cycle per period
    // RULE8 divide ratio
    assign ratio = {1'b0, cfg_reg.link_clock_divider} + 3'h1;
    assign run = cfg_reg.link_enable & ~stop_req;
    assign div_cnt_next = (!run || div_cnt_reg == cfg_reg.link_clock_divider) ?
                          2'h0 : div_cnt_reg + 2'h1;
    // a tick marks the start of a link clock period
    assign tick = run & (div_cnt_next == 2'h0);

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_cnt_reg <= 2'h0;
        end else begin
            div_cnt_reg <= div_cnt_next;
        end
    end

    // link clock pin; a stop waits for nothing since the pin copies the tick, which a stop blocks
    // RULE5 RULE10 RULE21 clock shape
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_link_clk <= 1'b0;
            o_link_active <= 1'b0;
        end else begin
            o_link_clk <= tick;
            o_link_active <= cfg_reg.link_enable;
        end
    end

    // window decode and launch; a pending error cancels the new access
    // RULE1 window decode
    assign in_window = (i_addr[15:8] == BLK_PAGE) | (i_addr[15:8] == NBLK_PAGE);
    assign launch = (i_wr | i_rd) & in_window & cfg_reg.link_enable &
                    (state_reg == DLI_IDLE) & ~err_reg;
    assign cancel = (i_wr | i_rd) & in_window & cfg_reg.link_enable & err_reg;

    // byte part for the current transfer cycle, high nibble first in 4-line mode
    always_comb begin
        unique case (state_reg)
            DLI_CMD: cur_byte = txn_reg.rwb ? CMD_READ : CMD_WRITE;
            DLI_ADDR: cur_byte = txn_reg.addr;
            DLI_DATA: cur_byte = txn_reg.data;
            default: cur_byte = 8'h00;
        endcase
        if (cfg_reg.link_width_select) begin
            part = cur_byte;
        end else if (!nib_reg) begin
            part = {NIB_ZERO, cur_byte[7:4]};
        end else begin
            part = {NIB_ZERO, cur_byte[3:0]};
        end
    end
    assign last_part = cfg_reg.link_width_select | nib_reg;
    // acknowledge: all active lanes sampled high
    assign ack_seen = ((i_dat_in & lanes) == lanes);
    // RULE15 RULE16 wait-state limit
    assign timeout_hit = (state_reg == DLI_ACK) & tick & ~ack_seen &
                         (wait_cnt_reg == cfg_reg.wait_state_limit);

    // transaction sequencer, leaves idle on launch and advances on link ticks
    // RULE17 RULE18 frame sequence
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= DLI_IDLE;
            nib_reg <= 1'b0;
            wait_cnt_reg <= 4'h0;
        end else if (!cfg_reg.link_enable) begin
            state_reg <= DLI_IDLE;
            nib_reg <= 1'b0;
            wait_cnt_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                DLI_IDLE: begin
                    if (launch) begin
                        state_reg <= DLI_CMD;
                    end
                    nib_reg <= 1'b0;
                end
                DLI_CMD, DLI_ADDR, DLI_DATA: begin
                    if (tick) begin
                        nib_reg <= ~last_part;
                        wait_cnt_reg <= 4'h0;
                        if (last_part) begin
                            if (state_reg == DLI_CMD) begin
                                state_reg <= DLI_ADDR;
                            end else if (state_reg == DLI_ADDR && !txn_reg.rwb) begin
                                state_reg <= DLI_DATA;
                            end else begin
                                state_reg <= DLI_ACK;
                            end
                        end
                    end
                end
                DLI_ACK: begin
                    if (tick) begin
                        // RULE13 count wait states
                        if (ack_seen) begin
                            state_reg <= txn_reg.rwb ? DLI_RDAT : DLI_IDLE;
                        end else if (timeout_hit) begin
                            state_reg <= DLI_IDLE;
                        end else begin
                            wait_cnt_reg <= wait_cnt_reg + 4'h1;
                        end
                    end
                end
                DLI_RDAT: begin
                    if (tick) begin
                        nib_reg <= ~last_part;
                        if (last_part) begin
                            state_reg <= DLI_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= DLI_IDLE;
                end
            endcase
        end
    end

    // capture of transaction attributes, address and data
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            txn_reg <= '0;
        end else if (launch) begin
            txn_reg.rwb <= i_rd;
            txn_reg.nblk <= (i_addr[15:8] == NBLK_PAGE);
            txn_reg.addr <= i_addr[7:0];
            txn_reg.data <= i_rd ? 8'h00 : i_wdata;
        end else if (state_reg == DLI_RDAT && tick) begin
            // read data builds up as it arrives, final at the last part
            if (cfg_reg.link_width_select) begin
                txn_reg.data <= i_dat_in;
            end else if (!nib_reg) begin
                txn_reg.data <= {i_dat_in[3:0], txn_reg.data[3:0]};
            end else begin
                txn_reg.data <= {txn_reg.data[7:4], i_dat_in[3:0]};
            end
        end
    end

    // busy flag
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_reg != DLI_IDLE) | launch;
        end
    end

    // error flags: a set in the clearing cycle wins over the clear
    // RULE20 error summary
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            err_reg <= 1'b0;
            timeout_error_flag_reg <= 1'b0;
            cnclf_reg <= 1'b0;
        end else begin
            err_reg <= timeout_hit | cancel | (err_reg & ~err_clear);
            timeout_error_flag_reg <= timeout_hit | (timeout_error_flag_reg & ~err_clear);
            cnclf_reg <= cancel | (cnclf_reg & ~err_clear);
        end
    end

    // interrupt outputs; the error line has no local mask
    // RULE12 interrupt gate
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_target_irq <= 1'b0;
            o_error_irq <= 1'b0;
        end else begin
            o_target_irq <= cfg_reg.link_enable & cfg_reg.target_interrupt_enable &
                            i_target_int;
            o_error_irq <= err_reg;
        end
    end

    // data pins: released when disabled, low when idle or stopped
    // RULE3 RULE4 RULE6 RULE19 lane drive
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_dat_out <= 8'h00;
            o_dat_oe_n <= LANES_ALL;
        end else if (!cfg_reg.link_enable) begin
            o_dat_out <= 8'h00;
            o_dat_oe_n <= LANES_ALL;
        end else if (stop_req) begin
            o_dat_out <= 8'h00;
            o_dat_oe_n <= ~lanes;
        end else begin
            unique case (state_reg)
                DLI_CMD, DLI_ADDR, DLI_DATA: begin
                    if (tick) begin
                        o_dat_out <= part & lanes;
                    end
                    o_dat_oe_n <= ~lanes;
                end
                DLI_ACK, DLI_RDAT: begin
                    // turned round so the target can answer
                    o_dat_out <= 8'h00;
                    o_dat_oe_n <= LANES_ALL;
                end
                default: begin
                    o_dat_out <= 8'h00;
                    o_dat_oe_n <= ~lanes;
                end
            endcase
        end
    end

    // register read port, data one cycle after the strobe
    // RULE22 reserved reads zero
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                CTL0_ADDR: o_rdata <= {cfg_reg.link_enable, cfg_reg.link_width_select,
                                       cfg_reg.stop_in_wait, 3'h0,
                                       cfg_reg.link_clock_divider};
                CTL1_ADDR: o_rdata <= {cfg_reg.target_interrupt_enable, 3'h0,
                                       cfg_reg.wait_state_limit};
                STAT0_ADDR: o_rdata <= {err_reg, 1'b0, cnclf_reg, timeout_error_flag_reg, 4'h0};
                STAT1_ADDR: o_rdata <= {i_target_int, busy_reg, 6'h00};
                ATTR_ADDR: o_rdata <= {txn_reg.rwb, 1'b1, 1'b0, txn_reg.nblk, 4'h0};
                CADR_ADDR: o_rdata <= txn_reg.addr;
                DHI_ADDR: o_rdata <= 8'h00;
                DLO_ADDR: o_rdata <= txn_reg.data;
                // window reads return the last captured data byte
                default: o_rdata <= in_window ? txn_reg.data : 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // checks
    // RULE10 RULE21 short high phase
    a_clk_high_one: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE10
        (o_link_clk && ratio > 3'h1) |=> !o_link_clk)
        else $error("link clock high longer than one bus cycle");
    // RULE3 release when disabled
    a_disabled_release: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE3
        !cfg_reg.link_enable |=> (o_dat_oe_n == LANES_ALL) && !o_link_clk)
        else $error("pins not released while disabled");
    // RULE4 idle lanes low
    a_idle_low: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE4
        (cfg_reg.link_enable && state_reg == DLI_IDLE)
        |=> (o_dat_out == 8'h00) && ((o_dat_oe_n & LANES_LOW) == 8'h00))
        else $error("idle lanes not driven low");
    // RULE6 upper lanes unused
    a_narrow_upper: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE6
        !cfg_reg.link_width_select |=> o_dat_oe_n[7:4] == 4'hF)
        else $error("upper lanes used in 4-line mode");
    // RULE2 RULE11 enable fields frozen
    a_lock_enable: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE11
        (locked && wr_ctl0) |=> $stable(cfg_reg.link_enable)
        && $stable(cfg_reg.link_width_select) && $stable(cfg_reg.link_clock_divider))
        else $error("write-once field changed after enable");
    // RULE14 timeout field frozen
    a_lock_timeout: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE14
        (locked && wr_ctl1) |=> $stable(cfg_reg.wait_state_limit))
        else $error("timeout field changed after enable");
    // RULE13 timeout flagged
    a_timeout_flag: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE13
        timeout_hit |=> timeout_error_flag_reg && err_reg && state_reg == DLI_IDLE)
        else $error("timeout not flagged");
    // RULE20 summary not masked
    a_err_summary: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE20
        timeout_error_flag_reg |-> err_reg ##1 o_error_irq)
        else $error("summary flag missing for timeout");
    // RULE12 interrupt gated
    a_irq_gate: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE12
        !cfg_reg.target_interrupt_enable |=> !o_target_irq)
        else $error("target interrupt passed while disabled");
    // RULE7 RULE19 stopped link low
    a_stop_clk: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE19
        stop_req |=> !o_link_clk && o_dat_out == 8'h00)
        else $error("link not held low while stopped");
    // RULE17 frame start
    a_start_busy: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE17
        launch |=> busy_reg && state_reg == DLI_CMD)
        else $error("launch did not start a frame");

    c_write_done: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
        state_reg == DLI_ACK && tick && ack_seen && !txn_reg.rwb);
    c_read_done: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
        state_reg == DLI_RDAT && tick && last_part);
    c_timeout: cover property (@(posedge i_mclk) disable iff (i_sys_rst) timeout_hit);
    c_cancel: cover property (@(posedge i_mclk) disable iff (i_sys_rst) cancel);
endmodule : dli_initiator

// file: tb/dli_target_model.sv
// Purpose: behavioural target die that answers link frames
// Assumes: eight-line mode; frame steps on cycles where the link clock is high
// Notes: it drives 00 on every lane whenever it is not answering, so undriven reads 00
`timescale 1ns/1ps
module dli_target_model
    import dli_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_link_clk,
    input wire logic [7:0] i_dat_out,
    input wire logic [7:0] i_dat_oe_n,
    input wire logic [3:0] i_waits,
    input wire logic [7:0] i_rd_val,
    output logic [7:0] o_dat
);
    logic [1:0] phase_reg;
    logic [3:0] left_reg;
    logic is_rd_reg;
    // frame follower; a bench-set wait count may exceed the limit on purpose
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase_reg <= 2'h0;
            left_reg <= 4'h0;
            is_rd_reg <= 1'b0;
            o_dat <= 8'h00;
        end else if (i_link_clk) begin
            case (phase_reg)
                2'h0: if (i_dat_oe_n == 8'h00 &&
                          (i_dat_out == CMD_WRITE || i_dat_out == CMD_READ)) begin
                    is_rd_reg <= (i_dat_out == CMD_READ);
                    left_reg <= (i_dat_out == CMD_READ) ? 4'h1 : 4'h2;
                    phase_reg <= 2'h1;
                end
                2'h1: if (left_reg == 4'h1) begin
                    phase_reg <= 2'h2;
                    left_reg <= i_waits;
                    o_dat <= (i_waits == 4'h0) ? 8'hFF : 8'h00;
                end else begin
                    left_reg <= left_reg - 4'h1;
                end
                // read data after the ack tick
                2'h2: if (left_reg == 4'h0) begin
                    o_dat <= is_rd_reg ? i_rd_val : 8'h00;
                    phase_reg <= is_rd_reg ? 2'h3 : 2'h0;
                end else begin
                    left_reg <= left_reg - 4'h1;
                    o_dat <= (left_reg == 4'h1) ? 8'hFF : 8'h00;
                end
                default: begin
                    o_dat <= 8'h00;
                    phase_reg <= 2'h0;
                end
            endcase
        end
    end
endmodule : dli_target_model

// file: tb/dli_initiator_tb.sv
// Purpose: self-checking bench for the die link initiator
// Assumes: divider code 01 during frames so each tick is one high cycle
// Notes: lane levels are resolved here from the initiator's enables alone
`timescale 1ns/1ps
module dli_initiator_tb;
    import dli_pkg::*;
    logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic i_special_mode = 1'b0, i_stop_mode = 1'b0, i_wait_mode = 1'b0, i_target_int = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0] i_wdata = 8'h00, o_rdata, o_dat_out, o_dat_oe_n, m_dat, rv, pr, hr;
    logic o_link_active, o_link_clk, o_target_irq, o_error_irq;
    logic [3:0] waits = 4'h0;
    logic [7:0] rd_val = 8'h96;
    wire logic [7:0] i_dat_in = (o_dat_oe_n & m_dat) | (~o_dat_oe_n & o_dat_out);
    int miscompares = 0, tests_run = 0, cyc = 0, n;
    logic [7:0] frame[$];
    logic [7:0] rows[4][3] = '{'{8'h00, 8'h14, 8'h14}, '{8'h01, 8'h02, 8'h01},
        '{8'h02, 8'h03, 8'h01}, '{8'h03, 8'h04, 8'h01}};
    dli_initiator dut (.i_mclk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_special_mode, .i_stop_mode, .i_wait_mode, .o_link_active, .o_link_clk, .o_dat_out,
        .o_dat_oe_n, .i_dat_in, .i_target_int, .o_target_irq, .o_error_irq);
    dli_target_model peer (.i_mclk, .i_sys_rst, .i_link_clk(o_link_clk), .i_dat_out(o_dat_out),
        .i_dat_oe_n(o_dat_oe_n), .i_waits(waits), .i_rd_val(rd_val), .o_dat(m_dat));
    // clock
    initial begin
        forever #2 i_mclk = ~i_mclk;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    // driven lane values seen on ticks; idle zeros are skipped
    always @(posedge i_mclk) begin
        if (o_link_clk === 1'b1 && o_dat_oe_n === 8'h00 && o_dat_out !== 8'h00) begin
            frame.push_back(o_dat_out);
        end
    end
    task automatic step();
        @(posedge i_mclk);
        #1;
    endtask : step
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd
    task automatic idle_wait();
        rv = 8'h40;
        for (n = 0; n < 200 && rv[6] !== 1'b0; n++) rd(STAT1_ADDR, rv);
    endtask : idle_wait
    task automatic measure();
        pr = 8'h00;
        hr = 8'h00;
        for (n = 0; n < 20 && o_link_clk !== 1'b0; n++) step();
        for (n = 0; n < 20 && o_link_clk !== 1'b1; n++) step();
        while (o_link_clk === 1'b1 && pr < 8'h14) begin pr++; hr++; step(); end
        while (o_link_clk === 1'b0 && pr < 8'h14) begin pr++; step(); end
    endtask : measure
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (8) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        // reset state, size bit, unmapped read
        rd(CTL0_ADDR, rv); chk(rv, 8'h00);
        rd(ATTR_ADDR, rv); chk(rv, 8'h40);
        rd(16'h00E0, rv); chk(rv, 8'h00);
        chk(o_dat_oe_n, 8'hFF);
        $display("reset test done");
        // write-once after enable, reserved bits zero
        wr(CTL1_ADDR, 8'hF2);
        wr(CTL0_ADDR, 8'hDD);
        rd(CTL0_ADDR, rv); chk(rv, 8'hC1);
        wr(CTL0_ADDR, 8'h23);
        rd(CTL0_ADDR, rv); chk(rv, 8'hE1);
        wr(CTL1_ADDR, 8'h0F);
        rd(CTL1_ADDR, rv); chk(rv, 8'h02);
        chk({o_link_active, 7'h00}, 8'h80);
        // clock held low while waiting with stop-in-wait set
        i_wait_mode <= 1'b1;
        step(); step();
        for (n = 0; n < 8; n++) begin step(); chk({o_link_clk, 7'h00}, 8'h00); end
        wr(CTL0_ADDR, 8'h03);
        measure(); chk(pr, 8'h02);
        i_wait_mode <= 1'b0;
        // idle command on all eight lanes
        chk(o_dat_oe_n, 8'h00);
        chk(o_dat_out, 8'h00);
        i_target_int <= 1'b1;
        wr(CTL1_ADDR, 8'h82);
        step(); chk({o_target_irq, 7'h00}, 8'h80);
        rd(STAT1_ADDR, rv); chk(rv, 8'h80);
        wr(CTL1_ADDR, 8'h02);
        step(); chk({o_target_irq, 7'h00}, 8'h00);
        i_target_int <= 1'b0;
        $display("config tests done");
        // blocking write, acknowledge at the limit
        waits <= 4'h2;
        wr(16'h0210, 8'h3C);
        idle_wait();
        chk(frame.size(), 8'h03);
        foreach (frame[i]) begin
            chk(frame[i], (i == 0) ? CMD_WRITE : (i == 1) ? 8'h10 : 8'h3C);
        end
        rd(STAT0_ADDR, rv); chk(rv, 8'h00);
        rd(ATTR_ADDR, rv); chk(rv, 8'h40);
        frame.delete();
        waits <= 4'h0;
        rd(16'h0322, rv);
        idle_wait();
        chk(frame.size(), 8'h02);
        chk(frame[0], CMD_READ);
        chk(frame[1], 8'h22);
        rd(DLO_ADDR, rv); chk(rv, 8'h96);
        rd(ATTR_ADDR, rv); chk(rv, 8'hD0);
        $display("transfer tests done");
        waits <= 4'h3;
        wr(16'h0211, 8'h5A);
        idle_wait();
        rd(STAT0_ADDR, rv); chk(rv, 8'h90);
        chk({o_error_irq, 7'h00}, 8'h80);
        wr(16'h0212, 8'h01);
        rd(STAT0_ADDR, rv); chk(rv, 8'hB0);
        wr(STAT0_ADDR, 8'h80);
        rd(STAT0_ADDR, rv); chk(rv, 8'h00);
        $display("error tests done");
        // stop mode drives clock and lanes low
        i_stop_mode <= 1'b1;
        step(); step();
        for (n = 0; n < 8; n++) begin
            step();
            chk({o_link_clk, 7'h00} | o_dat_out, 8'h00);
        end
        i_stop_mode <= 1'b0;
        // divider rows, free in special mode
        i_special_mode <= 1'b1;
        foreach (rows[i]) begin
            wr(CTL0_ADDR, 8'hC0 | rows[i][0]);
            measure();
            chk(pr, rows[i][1]);
            chk(hr, rows[i][2]);
        end
        $display("divider tests done");
        // four-line mode releases the upper lanes
        wr(CTL0_ADDR, 8'h81);
        step(); chk(o_dat_oe_n, 8'hF0);
        wr(CTL0_ADDR, 8'h00);
        step(); chk(o_dat_oe_n, 8'hFF);
        chk({o_link_active, o_link_clk, 6'h00}, 8'h00);
        // reset in mid-run releases an enabled link
        wr(CTL0_ADDR, 8'hC1);
        i_sys_rst <= 1'b1;
        step(); step();
        i_sys_rst <= 1'b0;
        rd(CTL0_ADDR, rv); chk(rv, 8'h00);
        chk(o_dat_oe_n, 8'hFF);
        $display("mode tests done");
        tally_and_finish();
    end
endmodule : dli_initiator_tb
